// ===== logic/pomca_array.v
// output logic cell array: two groups of eight cells, mcu access, pin routing
//
// Behaviour
// - sixteen cells, groups AB and BC
// - unassigned output placed on a group port
// - xor stage sets term polarity
// - mux picks registered or combinational, feeds back
// - storage is D, T, JK or SR
// - clock from product term or pin rising
// - high preset/clear; clear ORs two terms
// - term budgets 3+6, 4+5, 4+6
// - borrowed term serves one cell only
// - expansion consumes cells, adds delay
// - mcu loads/reads cell n on bit n
// - mcu load beats clock, preset, clear
// - edge or level loading by configuration
// - one mask per group, resets 00h
// - mask bit one blocks mcu write
// - driver enable is term OR direction
// - no enable equation: driver on from the first clock after reset; a port b pin takes the first group cell's equation for both groups
// - internal node leaves pin free
// - port c tap bits never driven
// - small package: first group port b only
// - feedback exported as two byte sets
`timescale 1ns/1ns
`include "pomca_consts.vh"
module pomca_array #(
	parameter AB_NPT = `POMCA_AB_NATIVE + `POMCA_AB_BORROW,
	parameter BC_NPT = `POMCA_BC_NATIVE + `POMCA_BC_BORROW_HI
) (
	input  wire                CLK_I,
	input  wire                RST_N_I,
	input  wire                SMALL_PKG_I,
	input  wire                SEL_I,
	input  wire [1:0]          ADDR_I,
	input  wire                WR_STB_I,
	input  wire                RD_STB_I,
	input  wire [7:0]          DATA_I,
	output reg  [7:0]          DATA_O,
	input  wire                LEVEL_LOAD_I,
	input  wire [8*AB_NPT-1:0] AB_PT_I,
	input  wire [8*BC_NPT-1:0] BC_PT_I,
	input  wire [15:0]         PT_COUNT_OK_I,
	input  wire [15:0]         INVERT_I,
	input  wire [15:0]         REG_SEL_I,
	input  wire [31:0]         FF_TYPE_I,
	input  wire [15:0]         USE_PIN_CLK_I,
	input  wire                LOGIC_CLK_PIN_I,
	input  wire [15:0]         PT_CLK_I,
	input  wire [15:0]         PRESET_PT_I,
	input  wire [31:0]         CLEAR_PT_I,
	input  wire [7:0]          AB_PORT_SEL_I,
	input  wire [7:0]          BC_PORT_SEL_I,
	input  wire [15:0]         PIN_ASSIGNED_I,
	input  wire [15:0]         INTERNAL_NODE_I,
	input  wire [15:0]         OE_EQN_DEFINED_I,
	input  wire [15:0]         OE_PT_I,
	input  wire [7:0]          DIR_A_I,
	input  wire [7:0]          DIR_B_I,
	input  wire [7:0]          DIR_C_I,
	output reg  [7:0]          PA_O,
	output reg  [7:0]          PA_OE_N_O,
	output reg  [7:0]          PB_O,
	output reg  [7:0]          PB_OE_N_O,
	output reg  [7:0]          PC_O,
	output reg  [7:0]          PC_OE_N_O,
	output wire [7:0]          FIRST_GROUP_FEEDBACK_O,
	output wire [7:0]          SECOND_GROUP_FEEDBACK_O,
	output wire [15:0]         EXPANSION_DELAY_O
);
	// ==========================================================
	// mcu registers
	// ==========================================================
	reg  [7:0] group_ab_write_block_mask_reg;
	reg  [7:0] group_bc_write_block_mask_reg;
	reg        wr_stb_reg;
	reg  [1:0] addr_reg;
	reg  [7:0] data_reg;
	wire [7:0] ab_q;
	wire [7:0] bc_q;
	wire [7:0] ab_out;
	wire [7:0] bc_out;

	// decode a select on this block's register set
	function hit;
		input       sel;
		input [1:0] addr;
		input [1:0] want;
		begin
			hit = sel & (addr == want);
		end
	endfunction

	// remember strobe, address and data to detect the trailing edge
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_stb_reg <= 1'b0;
			addr_reg   <= 2'h0;
			data_reg   <= 8'h00;
		end else begin
			wr_stb_reg <= WR_STB_I & SEL_I;
			if (WR_STB_I & SEL_I) begin
				addr_reg <= ADDR_I;
				data_reg <= DATA_I;
			end
		end
	end

	// level loading acts every cycle of the strobe, edge loading once at its end
	wire       trail    = wr_stb_reg & ~(WR_STB_I & SEL_I);
	wire       lvl      = LEVEL_LOAD_I & WR_STB_I;
	wire       edg      = ~LEVEL_LOAD_I & trail;
	wire [1:0] ld_addr  = lvl ? ADDR_I : addr_reg;
	wire [7:0] ld_data  = lvl ? DATA_I : data_reg;
	wire       ld_sel   = lvl ? SEL_I : edg;
	wire       ld_ab    = hit(ld_sel, ld_addr, `POMCA_SEL_AB_DATA);
	wire       ld_bc    = hit(ld_sel, ld_addr, `POMCA_SEL_BC_DATA);
	wire [7:0] ab_load  = {8{ld_ab}} & ~group_ab_write_block_mask_reg;
	wire [7:0] bc_load  = {8{ld_bc}} & ~group_bc_write_block_mask_reg;

	// mask registers, written on the strobe
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			group_ab_write_block_mask_reg <= `POMCA_MASK_RST;
			group_bc_write_block_mask_reg <= `POMCA_MASK_RST;
		end else if (WR_STB_I) begin
			if (hit(SEL_I, ADDR_I, `POMCA_SEL_AB_MASK))
				group_ab_write_block_mask_reg <= DATA_I;
			if (hit(SEL_I, ADDR_I, `POMCA_SEL_BC_MASK))
				group_bc_write_block_mask_reg <= DATA_I;
		end
	end

	// read path, registered data output
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DATA_O <= 8'h00;
		end else if (RD_STB_I & SEL_I) begin
			case (ADDR_I)
				`POMCA_SEL_AB_DATA: DATA_O <= ab_q;
				`POMCA_SEL_BC_DATA: DATA_O <= bc_q;
				`POMCA_SEL_AB_MASK: DATA_O <= group_ab_write_block_mask_reg;
				`POMCA_SEL_BC_MASK: DATA_O <= group_bc_write_block_mask_reg;
				default:            DATA_O <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// clock edge detection
	// ==========================================================
	reg        pin_clk_reg;
	reg [15:0] pt_clk_reg;
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pin_clk_reg <= 1'b0;
			pt_clk_reg  <= 16'h0000;
		end else begin
			pin_clk_reg <= LOGIC_CLK_PIN_I;
			pt_clk_reg  <= PT_CLK_I;
		end
	end
	wire        pin_rise = LOGIC_CLK_PIN_I & ~pin_clk_reg;
	wire [15:0] pt_rise  = PT_CLK_I & ~pt_clk_reg;

	// ==========================================================
	// sixteen cells
	// ==========================================================
	// terms past a cell's budget, or unclaimed by it, are masked by the allocator
	// configuration: each term bit is owned by one cell only
	genvar n;
	generate
		for (n = 0; n < 8; n = n + 1) begin : g_cell
			// first group: 3 native + 6 borrowed
			pomca_cell #(.NPT(AB_NPT)) u_ab (
				.CLK_I          (CLK_I),
				.RST_N_I        (RST_N_I),
				.pt_i           (AB_PT_I[n*AB_NPT +: AB_NPT]),
				.invert_i       (INVERT_I[n]),
				.reg_sel_i      (REG_SEL_I[n]),
				.ff_type_i      (FF_TYPE_I[2*n +: 2]),
				.use_pin_clk_i  (USE_PIN_CLK_I[n]),
				.pin_clk_rise_i (pin_rise),
				.pt_clk_rise_i  (pt_rise[n]),
				.preset_i       (PRESET_PT_I[n]),
				.clear_i        (|CLEAR_PT_I[2*n +: 2]),
				.load_i         (ab_load[n]),
				.load_data_i    (ld_data[n]),
				.q_o            (ab_q[n]),
				.out_o          (ab_out[n])
			);
			// second group: 4 native + 5 (cells 0-3) or 6 (cells 4-7)
			pomca_cell #(.NPT(BC_NPT)) u_bc (
				.CLK_I          (CLK_I),
				.RST_N_I        (RST_N_I),
				.pt_i           ((n < 4) ? {1'b0, BC_PT_I[n*BC_NPT +: BC_NPT-1]}
				                         : BC_PT_I[n*BC_NPT +: BC_NPT]),
				.invert_i       (INVERT_I[8+n]),
				.reg_sel_i      (REG_SEL_I[8+n]),
				.ff_type_i      (FF_TYPE_I[16+2*n +: 2]),
				.use_pin_clk_i  (USE_PIN_CLK_I[8+n]),
				.pin_clk_rise_i (pin_rise),
				.pt_clk_rise_i  (pt_rise[8+n]),
				.preset_i       (PRESET_PT_I[8+n]),
				.clear_i        (|CLEAR_PT_I[16+2*n +: 2]),
				.load_i         (bc_load[n]),
				.load_data_i    (ld_data[n]),
				.q_o            (bc_q[n]),
				.out_o          (bc_out[n])
			);
		end
	endgenerate

	// ==========================================================
	// feedback and expansion
	// ==========================================================
	// feedback to the decode and complex arrays, always present
	assign FIRST_GROUP_FEEDBACK_O  = ab_out;
	assign SECOND_GROUP_FEEDBACK_O = bc_out;
	// a cell whose equation exceeds its budget is flagged as expanded (slower path)
	assign EXPANSION_DELAY_O = ~PT_COUNT_OK_I;

	// ==========================================================
	// pin routing and driver enables
	// ==========================================================
	// port_sel 0 picks the lower port (A for first, B for second), 1 the upper
	// pin assignment is informational: the allocator select and the small package input decide the port
	// keep a cell on the port its select names, unless it is an internal node
	function on_port;
		input node;
		input upper_sel;
		input want_upper;
		begin
			on_port = ~node & (upper_sel == want_upper);
		end
	endfunction

	// driver enable: term OR direction, or forced on when no equation exists
	function drv_en;
		input eqn_defined;
		input oe_term;
		input dir_bit;
		begin
			drv_en = eqn_defined ? (oe_term | dir_bit) : 1'b1;
		end
	endfunction

	// port c bits a second group cell may reach, and the bits the tap owns
	wire [7:0] pc_cell_bits = `POMCA_PC_CELL_MASK;
	wire [7:0] pc_tap_bits  = `POMCA_PC_TAP_MASK;

	// routing and enable bits, one per pin
	reg  [7:0] ab_to_a;
	reg  [7:0] ab_to_b;
	reg  [7:0] bc_to_b;
	reg  [7:0] bc_to_c;
	reg  [7:0] oe_a;
	reg  [7:0] oe_b;
	reg  [7:0] oe_c;
	integer    i;

	// per-cell routing and driver enables
	always @* begin
		for (i = 0; i < 8; i = i + 1) begin
			// unassigned outputs go where the allocator select puts them
			ab_to_a[i] = on_port(INTERNAL_NODE_I[i], AB_PORT_SEL_I[i], 1'b0)
			             & ~SMALL_PKG_I;
			ab_to_b[i] = on_port(INTERNAL_NODE_I[i], AB_PORT_SEL_I[i] | SMALL_PKG_I,
			                     1'b1);
			bc_to_b[i] = on_port(INTERNAL_NODE_I[8+i], BC_PORT_SEL_I[i], 1'b0);
			bc_to_c[i] = on_port(INTERNAL_NODE_I[8+i], BC_PORT_SEL_I[i], 1'b1)
			             & pc_cell_bits[i];
			// first group shares its enable bit between ports a and b
			oe_a[i] = drv_en(OE_EQN_DEFINED_I[i], OE_PT_I[i], DIR_A_I[i]);
			oe_b[i] = drv_en(OE_EQN_DEFINED_I[i], OE_PT_I[i], DIR_B_I[i]);
			oe_c[i] = drv_en(OE_EQN_DEFINED_I[8+i], OE_PT_I[8+i], DIR_C_I[i]);
		end
	end

	// next pin values and enables; a cell routed away leaves its driver off
	// port b is shared: a bit selected by both groups carries the OR of the two cells
	wire [7:0] pa_next    = ab_out & ab_to_a;
	wire [7:0] pb_next    = (ab_out & ab_to_b) | (bc_out & bc_to_b);
	wire [7:0] pc_next    = bc_out & bc_to_c & ~pc_tap_bits;
	wire [7:0] pa_oe_next = oe_a & ab_to_a;
	wire [7:0] pb_oe_next = oe_b & (ab_to_b | bc_to_b);
	wire [7:0] pc_oe_next = oe_c & bc_to_c & ~pc_tap_bits;

	// registered pin drive; enables active low
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PA_O      <= 8'h00;
			PB_O      <= 8'h00;
			PC_O      <= 8'h00;
			PA_OE_N_O <= 8'hff;
			PB_OE_N_O <= 8'hff;
			PC_OE_N_O <= 8'hff;
		end else begin
			PA_O      <= pa_next;
			PB_O      <= pb_next;
			PC_O      <= pc_next;
			PA_OE_N_O <= ~pa_oe_next;
			PB_OE_N_O <= ~pb_oe_next;
			PC_OE_N_O <= ~pc_oe_next;
		end
	end
endmodule

// ===== logic/pomca_consts.vh
// constants for the output logic cell array
`ifndef POMCA_CONSTS_VH
`define POMCA_CONSTS_VH
// register selects on the peripheral register space
`define POMCA_SEL_AB_DATA   2'h0
`define POMCA_SEL_BC_DATA   2'h1
`define POMCA_SEL_AB_MASK   2'h2
`define POMCA_SEL_BC_MASK   2'h3
// reset values
`define POMCA_MASK_RST      8'h00
`define POMCA_CELL_RST      8'h00
// flip-flop type encodings
`define POMCA_FF_D          2'h0
`define POMCA_FF_T          2'h1
`define POMCA_FF_JK         2'h2
`define POMCA_FF_SR         2'h3
// port c bits owned by the test access port (bits 0,1,5,6)
`define POMCA_PC_TAP_MASK   8'h63
// port c bits reachable by second group cells (2,3,4,7)
`define POMCA_PC_CELL_MASK  8'h9c
// port b bits reachable by second group cells (all)
`define POMCA_PB_CELL_MASK  8'hff
// product term budgets per cell
`define POMCA_AB_NATIVE     3
`define POMCA_AB_BORROW     6
`define POMCA_BC_NATIVE     4
`define POMCA_BC_BORROW_LO  5
`define POMCA_BC_BORROW_HI  6
`endif

// ===== logic/pomca_cell.v
// one output logic cell: polarity, flip-flop, output multiplexer
`timescale 1ns/1ns
`include "pomca_consts.vh"
module pomca_cell #(
	parameter NPT = 4
) (
	input  wire           CLK_I,
	input  wire           RST_N_I,
	input  wire [NPT-1:0] pt_i,
	input  wire           invert_i,
	input  wire           reg_sel_i,
	input  wire [1:0]     ff_type_i,
	input  wire           use_pin_clk_i,
	input  wire           pin_clk_rise_i,
	input  wire           pt_clk_rise_i,
	input  wire           preset_i,
	input  wire           clear_i,
	input  wire           load_i,
	input  wire           load_data_i,
	output wire           q_o,
	output wire           out_o
);
	// split terms: low half drives set/j, high half reset/k for jk and sr
	localparam HALF = NPT / 2;
	wire sum_all = |pt_i;
	wire sum_lo  = |pt_i[HALF-1:0];
	wire sum_hi  = |pt_i[NPT-1:HALF];
	// polarity stage
	wire d_in    = sum_all ^ invert_i;
	wire a_in    = sum_lo ^ invert_i;
	wire b_in    = sum_hi ^ invert_i;
	reg  q_reg;
	reg  q_next;
	wire tick    = use_pin_clk_i ? pin_clk_rise_i : pt_clk_rise_i;
	// next state by configured storage type
	always @* begin
		case (ff_type_i)
			`POMCA_FF_D:  q_next = d_in;
			`POMCA_FF_T:  q_next = q_reg ^ d_in;
			`POMCA_FF_JK: q_next = (a_in & ~q_reg) | (~b_in & q_reg);
			`POMCA_FF_SR: q_next = a_in | (~b_in & q_reg);
			default:      q_next = q_reg;
		endcase
	end
	// load wins, then clear, then preset, then clock tick
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q_reg <= 1'b0;
		end else if (load_i) begin
			q_reg <= load_data_i;
		end else if (clear_i) begin
			q_reg <= 1'b0;
		end else if (preset_i) begin
			q_reg <= 1'b1;
		end else if (tick) begin
			q_reg <= q_next;
		end
	end
	assign q_o   = q_reg;
	assign out_o = reg_sel_i ? q_reg : d_in;
endmodule

// ===== verification/pomca_array_props.sv
// assertion checker for the output logic cell array
`timescale 1ns/1ns
module pomca_array_props #(
	parameter AB_NPT = 9,
	parameter BC_NPT = 10
) (
	input wire        CLK_I,
	input wire        RST_N_I,
	input wire        SMALL_PKG_I,
	input wire        SEL_I,
	input wire [1:0]  ADDR_I,
	input wire        WR_STB_I,
	input wire        RD_STB_I,
	input wire [7:0]  DATA_I,
	input wire [7:0]  DATA_O,
	input wire        LEVEL_LOAD_I,
	input wire [15:0] PT_COUNT_OK_I,
	input wire [15:0] REG_SEL_I,
	input wire [7:0]  AB_PORT_SEL_I,
	input wire [15:0] INTERNAL_NODE_I,
	input wire [15:0] OE_EQN_DEFINED_I,
	input wire [7:0]  PA_OE_N_O,
	input wire [7:0]  PC_OE_N_O,
	input wire [7:0]  FIRST_GROUP_FEEDBACK_O,
	input wire [15:0] EXPANSION_DELAY_O
);
	reg  [7:0] mask_ab_reg;
	reg  [7:0] wdata_reg;
	// decoded bus cycles and the masked load difference
	wire       wr_ab = SEL_I && WR_STB_I && ADDR_I == 2'h0 && REG_SEL_I[7:0] == 8'hff;
	wire       rd_go = SEL_I && RD_STB_I && !WR_STB_I;
	wire       rd_ab = rd_go && ADDR_I == 2'h0 && REG_SEL_I[7:0] == 8'hff;
	wire       pa0   = !SMALL_PKG_I && !AB_PORT_SEL_I[0] && !INTERNAL_NODE_I[0];
	wire [7:0] ld_diff = (FIRST_GROUP_FEEDBACK_O ^ wdata_reg) & ~mask_ab_reg;
	// shadow of the first group mask and of the last write data
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mask_ab_reg <= 8'h00;
			wdata_reg   <= 8'h00;
		end else if (SEL_I && WR_STB_I) begin
			wdata_reg <= DATA_I;
			if (ADDR_I == 2'h2)
				mask_ab_reg <= DATA_I;
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// edge-mode cell write: strobe high one edge, then low
	sequence s_edge_wr; wr_ab && !LEVEL_LOAD_I ##1 !WR_STB_I; endsequence
	property p_tap; (PC_OE_N_O & 8'h63) == 8'h63; endproperty
	property p_expand; EXPANSION_DELAY_O == ~PT_COUNT_OK_I; endproperty
	property p_small; SMALL_PKG_I |=> PA_OE_N_O == 8'hff; endproperty
	property p_mask_rd; rd_go && ADDR_I == 2'h2 |=> DATA_O == mask_ab_reg; endproperty
	property p_lvl_load; wr_ab && LEVEL_LOAD_I |=> ld_diff == 8'h00; endproperty
	property p_edge_load; s_edge_wr |-> ##[1:2] ld_diff == 8'h00; endproperty
	property p_read; rd_ab |=> DATA_O == $past(FIRST_GROUP_FEEDBACK_O); endproperty
	property p_no_eqn; pa0 && !OE_EQN_DEFINED_I[0] |=> !PA_OE_N_O[0]; endproperty
	a_tap: assert property (p_tap) else $error("tap pin enabled");
	a_expand: assert property (p_expand) else $error("expansion flag wrong");
	a_small: assert property (p_small) else $error("port a driven");
	a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
	a_lvl_load: assert property (p_lvl_load) else $error("level load wrong");
	a_edge_load: assert property (p_edge_load) else $error("edge load wrong");
	a_read: assert property (p_read) else $error("cell readback wrong");
	a_no_eqn: assert property (p_no_eqn) else $error("driver not enabled");
endmodule
bind pomca_array pomca_array_props #(.AB_NPT(AB_NPT), .BC_NPT(BC_NPT)) i_props (.*);

// ===== verification/pomca_mcu_model.sv
// mcu bus master model for the register space of the cell array
`timescale 1ns/1ns
module pomca_mcu_model (
	input  wire       clk_i,
	input  wire [7:0] rdata_i,
	output reg        sel_o = 1'b0,
	output reg  [1:0] addr_o = 2'h0,
	output reg        wr_o = 1'b0,
	output reg        rd_o = 1'b0,
	output reg  [7:0] data_o = 8'h00
);
	// write: strobe over one edge, low over one more before release
	task wr(input [1:0] a, input [7:0] d);
		@(negedge clk_i);
		sel_o = 1'b1;
		addr_o = a;
		data_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		@(negedge clk_i);
		sel_o = 1'b0;
		data_o = ~d; // released bus carries no stale value
	endtask
	// read: strobe over one edge, data registered on that edge
	task rd(input [1:0] a, output [7:0] d);
		@(negedge clk_i);
		sel_o = 1'b1;
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		sel_o = 1'b0;
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule

// ===== verification/pomca_array_test.sv
// self-checking testbench for the output logic cell array
`timescale 1ns/1ns
module pomca_array_test;
	reg         CLK_I = 1'b0, RST_N_I = 1'b0, SMALL_PKG_I = 1'b0, LEVEL_LOAD_I = 1'b1;
	reg         LOGIC_CLK_PIN_I = 1'b0;
	reg  [71:0] AB_PT_I = 72'h0;
	reg  [79:0] BC_PT_I = 80'h0;
	reg  [15:0] PT_COUNT_OK_I = 16'hffff, REG_SEL_I = 16'hffff, USE_PIN_CLK_I = 16'h0001;
	reg  [15:0] INVERT_I = 16'h0, PT_CLK_I = 16'h0, PRESET_PT_I = 16'h0, PIN_ASSIGNED_I = 16'h0;
	reg  [15:0] INTERNAL_NODE_I = 16'h0, OE_EQN_DEFINED_I = 16'h0, OE_PT_I = 16'h0;
	reg  [31:0] FF_TYPE_I = 32'h0, CLEAR_PT_I = 32'h0;
	reg  [7:0]  AB_PORT_SEL_I = 8'h00, BC_PORT_SEL_I = 8'hff, DIR_A_I = 8'h00;
	reg  [7:0]  DIR_B_I = 8'h00, DIR_C_I = 8'h00, rd_data;
	wire        SEL_I, WR_STB_I, RD_STB_I;
	wire [1:0]  ADDR_I;
	wire [7:0]  DATA_I, DATA_O, PA_O, PA_OE_N_O, PB_O, PB_OE_N_O, PC_O, PC_OE_N_O;
	wire [7:0]  FIRST_GROUP_FEEDBACK_O, SECOND_GROUP_FEEDBACK_O;
	wire [15:0] EXPANSION_DELAY_O;
	int         failures = 0, n_checks = 0;
	pomca_array i_dut (.*);
	pomca_mcu_model i_mcu (.clk_i(CLK_I), .rdata_i(DATA_O), .sel_o(SEL_I), .addr_o(ADDR_I),
		.wr_o(WR_STB_I), .rd_o(RD_STB_I), .data_o(DATA_I));
	// 20 MHz clock
	always #25 CLK_I = ~CLK_I;
	// compare one byte, count it and report a mismatch
	task chk(input string n, input [7:0] e, input [7:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task rdc(input [1:0] a, input [7:0] e, input string n);
		i_mcu.rd(a, rd_data);
		chk(n, e, rd_data);
	endtask
	task cyc(input int k);
		repeat (k) @(negedge CLK_I);
	endtask
	// pulse the dedicated clock pin; the rise is seen at the next clock edge
	task pclk;
		LOGIC_CLK_PIN_I = 1'b1;
		cyc(2);
		LOGIC_CLK_PIN_I = 1'b0;
		cyc(2);
	endtask
	task t_reset;
		rdc(2'h2, 8'h00, "mask_ab");
		rdc(2'h3, 8'h00, "mask_bc");
		rdc(2'h0, 8'h00, "cells_ab");
		chk("pc_tap_oe_n", 8'h63, PC_OE_N_O & 8'h63);
		chk("pc_oe_n", 8'h63, PC_OE_N_O);
		chk("pa_oe_n", 8'h00, PA_OE_N_O);
		$display("t_reset done");
	endtask
	task t_load;
		i_mcu.wr(2'h0, 8'ha5);
		i_mcu.wr(2'h1, 8'h3c);
		rdc(2'h0, 8'ha5, "cells_ab");
		rdc(2'h1, 8'h3c, "cells_bc");
		chk("fb_ab", 8'ha5, FIRST_GROUP_FEEDBACK_O);
		chk("fb_bc", 8'h3c, SECOND_GROUP_FEEDBACK_O);
		chk("pa", 8'ha5, PA_O);
		chk("pc", 8'h1c, PC_O & 8'h9c);
		$display("t_load done");
	endtask
	task t_mask;
		i_mcu.wr(2'h2, 8'h0f);
		rdc(2'h2, 8'h0f, "mask_ab");
		i_mcu.wr(2'h0, 8'hff);
		rdc(2'h0, 8'hf5, "cells_ab");
		i_mcu.wr(2'h2, 8'h00);
		$display("t_mask done");
	endtask
	task t_edge;
		LEVEL_LOAD_I = 1'b0;
		i_mcu.wr(2'h1, 8'hc3);
		i_mcu.wr(2'h0, 8'h5a);
		rdc(2'h1, 8'hc3, "cells_bc");
		rdc(2'h0, 8'h5a, "cells_ab");
		LEVEL_LOAD_I = 1'b1;
		$display("t_edge done");
	endtask
	// storage kinds, clock sources, preset and clear on first group cell 0
	task t_ff;
		AB_PT_I[0] = 1'b1;
		pclk;
		chk("d_pin", 8'h5b, FIRST_GROUP_FEEDBACK_O);
		FF_TYPE_I[1:0] = 2'h1;
		AB_PT_I[8:0] = 9'h1ff;
		pclk;
		chk("t", 8'h5a, FIRST_GROUP_FEEDBACK_O);
		FF_TYPE_I[1:0] = 2'h2;
		pclk;
		chk("jk", 8'h5b, FIRST_GROUP_FEEDBACK_O);
		FF_TYPE_I[1:0] = 2'h3;
		AB_PT_I[8:0] = 9'h000;
		pclk;
		chk("sr", 8'h5b, FIRST_GROUP_FEEDBACK_O);
		FF_TYPE_I[1:0] = 2'h0;
		USE_PIN_CLK_I[0] = 1'b0;
		PT_CLK_I[0] = 1'b1;
		cyc(2);
		chk("d_term", 8'h5a, FIRST_GROUP_FEEDBACK_O);
		PRESET_PT_I[0] = 1'b1;
		cyc(2);
		chk("preset", 8'h5b, FIRST_GROUP_FEEDBACK_O);
		PRESET_PT_I[0] = 1'b0;
		CLEAR_PT_I[1] = 1'b1;
		cyc(2);
		chk("clear", 8'h5a, FIRST_GROUP_FEEDBACK_O);
		// the load must show while clear is still high, before clear acts again
		fork
			i_mcu.wr(2'h0, 8'h5b);
			begin
				cyc(2);
				chk("load_over_clear", 8'h5b, FIRST_GROUP_FEEDBACK_O);
			end
		join
		CLEAR_PT_I[1] = 1'b0;
		$display("t_ff done");
	endtask
	task t_comb;
		REG_SEL_I[0] = 1'b0;
		INVERT_I[0] = 1'b1;
		cyc(1);
		chk("inv_0", 8'h5b, FIRST_GROUP_FEEDBACK_O);
		AB_PT_I[0] = 1'b1;
		cyc(1);
		chk("inv_1", 8'h5a, FIRST_GROUP_FEEDBACK_O);
		INVERT_I[0] = 1'b0;
		cyc(1);
		chk("true_1", 8'h5b, FIRST_GROUP_FEEDBACK_O);
		REG_SEL_I[0] = 1'b1;
		PT_COUNT_OK_I = 16'h8001;
		cyc(1);
		chk("exp_lo", 8'hfe, EXPANSION_DELAY_O[7:0]);
		chk("exp_hi", 8'h7f, EXPANSION_DELAY_O[15:8]);
		PT_COUNT_OK_I = 16'hffff;
		$display("t_comb done");
	endtask
	task t_pins;
		OE_EQN_DEFINED_I = 16'hffff;
		OE_PT_I = 16'h0001;
		DIR_A_I = 8'h02;
		cyc(2);
		chk("pa_oe_n", 8'hfc, PA_OE_N_O);
		OE_EQN_DEFINED_I = 16'h0000;
		INTERNAL_NODE_I = 16'h0004;
		cyc(2);
		chk("pa_oe_n", 8'h04, PA_OE_N_O);
		INTERNAL_NODE_I = 16'h0000;
		AB_PORT_SEL_I = 8'hff;
		cyc(2);
		chk("pb", 8'h5a, PB_O);
		chk("pb_oe_n", 8'h00, PB_OE_N_O);
		AB_PORT_SEL_I = 8'h00;
		SMALL_PKG_I = 1'b1;
		cyc(2);
		chk("pa_oe_n", 8'hff, PA_OE_N_O);
		chk("pb", 8'h5a, PB_O);
		SMALL_PKG_I = 1'b0;
		$display("t_pins done");
	endtask
	task complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// reset, then the scenarios in order
	initial begin
		cyc(5);
		RST_N_I = 1'b1;
		t_reset;
		t_load;
		t_mask;
		t_edge;
		t_ff;
		t_comb;
		t_pins;
		complete_run;
	end
	// watchdog: the scenarios need about 80 cycles
	initial begin
		repeat (5000) @(posedge CLK_I);
		failures++;
		complete_run;
	end
endmodule
